// ===== common/spidp_if.sv
// Serial link between host master and device slave
`timescale 1ns/100ps
interface spidp_if;
    logic sck;
    logic sdi;
    logic sdo;
    logic chip_select_low_n;

    modport dev (
        input  sck,
        input  sdi,
        input  chip_select_low_n,
        output sdo
    );

    modport host (
        output sck,
        output sdi,
        output chip_select_low_n,
        input  sdo
    );
endinterface

// ===== common/spidp_pkg.sv
// Shared constants for the serial datagram port, both ends
// Function
// - Device acts only while chip select low
// - Device samples data input on rising clock
// - Device updates data output after falling clock
// - Datagrams travel most significant bit first
// - Master gives at least forty clocks
// - Extra bits reappear forty clocks later
// - Chip select stays low whole transaction
// - Chip select rise executes shifted command
// - Only last forty bits form command
// - Bus clock at most half system clock
// - Extra ten percent margin on oscillator
// - Mode three: clock idles high
// - Registers clear to zero at reset; the clock and chip select flops reset to one
// - Write adds offset to seven-bit address
// - Top address bit selects write
// - Reply carries previously read register
// - Reply after write echoes write data
// - Status byte captured, returned in top bits
package spidp_pkg;
    localparam int DGRAM_W           = 40;
    localparam int DATA_W            = 32;
    localparam int ADDR_W            = 7;
    localparam int STAT_W            = 8;
    localparam int WRITE_BIT         = 39;
    localparam int ADDR_HI           = 38;
    localparam int STAT_RSVD_BIT     = 7;
    localparam int CNT_W             = 6;
    localparam logic [7:0] WRITE_OFFSET = 8'h80;
    localparam logic [7:0] READ_OFFSET  = 8'h00;
    // Device sees an edge three cycles late, host reads data out two late
    localparam int DEV_EDGE_LAT_CYC  = 3;
    localparam int HOST_SYNC_CYC     = 2;
    localparam int OSC_MARGIN_PCT    = 10;
    localparam int HALF_BASE_CYC     = DEV_EDGE_LAT_CYC + HOST_SYNC_CYC + 1;
    localparam int LINK_HALF_MIN_CYC =
        (HALF_BASE_CYC * (100 + OSC_MARGIN_PCT) + 99) / 100;
    localparam int LINK_HALF_CYC     = 8;
    localparam int LINK_GAP_CYC      = 8;
    localparam int LINK_GAP_MIN_CYC  = 5;
    localparam int TMR_W             = 16;
endpackage

// ===== design/spidp_dev.sv
// Device end: serial slave shifting datagrams and issuing commands
`timescale 1ns/100ps
module spidp_dev
    import spidp_pkg::*;
(
    // System
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    // Serial link
    spidp_if.dev                     LINK,
    // Register side
    output logic                     REG_WR,
    output logic                     REG_RD,
    output logic [ADDR_W-1:0]        REG_ADDR,
    output logic [DATA_W-1:0]        REG_WDATA,
    input  wire logic [DATA_W-1:0]   REG_RDATA,
    input  wire logic [STAT_W-1:0]   STATUS,
    // Frame state
    output logic                     BUSY,
    output logic                     SHORT_FRAME
);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_CAPT  = 2'b10
    } spidp_dst_t;

    // Synchronisers
    logic                sck_m_q;
    logic                sck_s_q;
    logic                sck_p_q;
    logic                sdi_m_q;
    logic                sdi_s_q;
    logic                cs_m_q;
    logic                cs_s_q;
    logic                sck_rise;
    logic                sck_fall;

    // Frame state
    spidp_dst_t          state_q;
    spidp_dst_t          state_d;
    logic [DGRAM_W-1:0]  sh_q;
    logic [DGRAM_W-1:0]  sh_d;
    logic [CNT_W-1:0]    cnt_q;
    logic [CNT_W-1:0]    cnt_d;
    logic                sdo_q;
    logic                sdo_d;
    logic                wr_q;
    logic                wr_d;
    logic                rd_q;
    logic                rd_d;
    logic [ADDR_W-1:0]   addr_q;
    logic [ADDR_W-1:0]   addr_d;
    logic [DATA_W-1:0]   wdata_q;
    logic [DATA_W-1:0]   wdata_d;
    logic [DATA_W-1:0]   reply_q;
    logic [DATA_W-1:0]   reply_d;
    logic [STAT_W-1:0]   stat_q;
    logic [STAT_W-1:0]   stat_d;
    logic                busy_q;
    logic                busy_d;
    logic                short_q;
    logic                short_d;

    // Two stages per pin, edges only from the second stage on
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sck_m_q <= 1'b1;
            sck_s_q <= 1'b1;
            sck_p_q <= 1'b1;
            sdi_m_q <= 1'b0;
            sdi_s_q <= 1'b0;
            cs_m_q  <= 1'b1;
            cs_s_q  <= 1'b1;
        end else begin
            sck_m_q <= LINK.sck;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
            sdi_m_q <= LINK.sdi;
            sdi_s_q <= sdi_m_q;
            cs_m_q  <= LINK.chip_select_low_n;
            cs_s_q  <= cs_m_q;
        end
    end

    assign sck_rise = sck_s_q & ~sck_p_q;
    assign sck_fall = ~sck_s_q & sck_p_q;

    always_comb begin
        state_d = state_q;
        sh_d    = sh_q;
        cnt_d   = cnt_q;
        sdo_d   = sdo_q;
        wr_d    = 1'b0;
        rd_d    = 1'b0;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        reply_d = reply_q;
        stat_d  = stat_q;
        busy_d  = busy_q;
        short_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // Clock and data ignored while deselected
                if (!cs_s_q) begin
                    sh_d    = {stat_q, reply_q};
                    sdo_d   = stat_q[STAT_W-1];
                    cnt_d   = '0;
                    busy_d  = 1'b1;
                    state_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_s_q) begin
                    busy_d = 1'b0;
                    if (cnt_q == CNT_W'(DGRAM_W)) begin
                        // Register holds the last forty bits
                        wr_d    = sh_q[WRITE_BIT];
                        rd_d    = ~sh_q[WRITE_BIT];
                        addr_d  = sh_q[ADDR_HI:DATA_W];
                        wdata_d = sh_q[DATA_W-1:0];
                        state_d = ST_CAPT;
                    end else begin
                        short_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end else if (sck_rise) begin
                    sh_d = {sh_q[DGRAM_W-2:0], sdi_s_q};
                    if (cnt_q != CNT_W'(DGRAM_W)) begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end else if (sck_fall) begin
                    // Oldest bit leaves forty clocks after entry
                    sdo_d = sh_q[DGRAM_W-1];
                end
            end
            ST_CAPT: begin
                if (rd_q) begin
                    reply_d = REG_RDATA;
                end else begin
                    reply_d = wdata_q;
                end
                stat_d                = STATUS;
                stat_d[STAT_RSVD_BIT] = 1'b0;
                state_d               = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= ST_IDLE;
            sh_q    <= '0;
            cnt_q   <= '0;
            sdo_q   <= 1'b0;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
            reply_q <= '0;
            stat_q  <= '0;
            busy_q  <= 1'b0;
            short_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sh_q    <= sh_d;
            cnt_q   <= cnt_d;
            sdo_q   <= sdo_d;
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            reply_q <= reply_d;
            stat_q  <= stat_d;
            busy_q  <= busy_d;
            short_q <= short_d;
        end
    end

    assign LINK.sdo    = sdo_q;
    assign REG_WR      = wr_q;
    assign REG_RD      = rd_q;
    assign REG_ADDR    = addr_q;
    assign REG_WDATA   = wdata_q;
    assign BUSY        = busy_q;
    assign SHORT_FRAME = short_q;

endmodule

// ===== design/spidp_host.sv
// Host end: mode 3 serial master sending one datagram per command
`timescale 1ns/100ps
module spidp_host
    import spidp_pkg::*;
#(
    parameter int HALF_CYC = LINK_HALF_CYC,
    parameter int GAP_CYC  = LINK_GAP_CYC
)
(
    // System
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    // Serial link
    spidp_if.host                    LINK,
    // Command
    input  wire logic                CMD_VALID,
    input  wire logic                CMD_WRITE,
    input  wire logic [ADDR_W-1:0]   CMD_ADDR,
    input  wire logic [DATA_W-1:0]   CMD_DATA,
    output logic                     CMD_READY,
    // Response
    output logic                     RSP_VALID,
    output logic [STAT_W-1:0]        RSP_STATUS,
    output logic [DATA_W-1:0]        RSP_DATA
);

    // Slow enough for the device's sampling plus oscillator margin
    if (HALF_CYC < LINK_HALF_MIN_CYC || HALF_CYC >= 2**TMR_W) begin : g_half
        $error("HALF_CYC out of range");
    end
    if (GAP_CYC < LINK_GAP_MIN_CYC || GAP_CYC >= 2**TMR_W) begin : g_gap
        $error("GAP_CYC out of range");
    end

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_LOW  = 3'b010,
        H_HIGH = 3'b011,
        H_GAP  = 3'b100
    } spidp_hst_t;

    localparam logic [TMR_W-1:0] HALF_LD = TMR_W'(HALF_CYC - 1);
    localparam logic [TMR_W-1:0] GAP_LD  = TMR_W'(GAP_CYC - 1);

    logic                sdo_m_q;
    logic                sdo_s_q;
    spidp_hst_t          state_q;
    spidp_hst_t          state_d;
    logic [TMR_W-1:0]    tmr_q;
    logic [TMR_W-1:0]    tmr_d;
    logic [CNT_W-1:0]    bits_q;
    logic [CNT_W-1:0]    bits_d;
    logic [DGRAM_W-1:0]  tx_q;
    logic [DGRAM_W-1:0]  tx_d;
    logic [DGRAM_W-1:0]  rx_q;
    logic [DGRAM_W-1:0]  rx_d;
    logic                sck_q;
    logic                sck_d;
    logic                sdi_q;
    logic                sdi_d;
    logic                cs_q;
    logic                cs_d;
    logic                rdy_q;
    logic                rdy_d;
    logic                rsp_q;
    logic                rsp_d;
    logic [7:0]          abyte;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sdo_m_q <= 1'b0;
            sdo_s_q <= 1'b0;
        end else begin
            sdo_m_q <= LINK.sdo;
            sdo_s_q <= sdo_m_q;
        end
    end

    // Write sets the top address bit by adding the offset
    assign abyte = {1'b0, CMD_ADDR}
                 + (CMD_WRITE ? WRITE_OFFSET : READ_OFFSET);

    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q;
        bits_d  = bits_q;
        tx_d    = tx_q;
        rx_d    = rx_q;
        sck_d   = sck_q;
        sdi_d   = sdi_q;
        cs_d    = cs_q;
        rdy_d   = rdy_q;
        rsp_d   = 1'b0;
        if (tmr_q != '0) begin
            tmr_d = tmr_q - TMR_W'(1);
        end
        case (state_q)
            H_IDLE: begin
                // Ready comes up one cycle after entering idle from reset; H_GAP raises it on the way back to idle
                if (!rdy_q) begin
                    rdy_d = 1'b1;
                end
                if (CMD_VALID && rdy_q) begin
                    tx_d    = {abyte, CMD_DATA};
                    cs_d    = 1'b0;
                    rdy_d   = 1'b0;
                    bits_d  = '0;
                    tmr_d   = HALF_LD;
                    state_d = H_LEAD;
                end
            end
            H_LEAD, H_HIGH: begin
                if (tmr_q == '0) begin
                    if (bits_q == CNT_W'(DGRAM_W)) begin
                        cs_d    = 1'b1;
                        tmr_d   = GAP_LD;
                        state_d = H_GAP;
                    end else begin
                        sck_d   = 1'b0;
                        sdi_d   = tx_q[DGRAM_W-1];
                        tx_d    = {tx_q[DGRAM_W-2:0], 1'b0};
                        tmr_d   = HALF_LD;
                        state_d = H_LOW;
                    end
                end
            end
            H_LOW: begin
                if (tmr_q == '0) begin
                    sck_d   = 1'b1;
                    rx_d    = {rx_q[DGRAM_W-2:0], sdo_s_q};
                    bits_d  = bits_q + CNT_W'(1);
                    tmr_d   = HALF_LD;
                    state_d = H_HIGH;
                end
            end
            H_GAP: begin
                if (tmr_q == '0) begin
                    rsp_d   = 1'b1;
                    rdy_d   = 1'b1;
                    state_d = H_IDLE;
                end
            end
            default: begin
                state_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= H_IDLE;
            tmr_q   <= '0;
            bits_q  <= '0;
            tx_q    <= '0;
            rx_q    <= '0;
            sck_q   <= 1'b1;
            sdi_q   <= 1'b0;
            cs_q    <= 1'b1;
            rdy_q   <= 1'b0;
            rsp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            bits_q  <= bits_d;
            tx_q    <= tx_d;
            rx_q    <= rx_d;
            sck_q   <= sck_d;
            sdi_q   <= sdi_d;
            cs_q    <= cs_d;
            rdy_q   <= rdy_d;
            rsp_q   <= rsp_d;
        end
    end

    assign LINK.sck               = sck_q;
    assign LINK.sdi               = sdi_q;
    assign LINK.chip_select_low_n = cs_q;
    assign CMD_READY              = rdy_q;
    assign RSP_VALID              = rsp_q;
    assign RSP_STATUS             = rx_q[DGRAM_W-1:DATA_W];
    assign RSP_DATA               = rx_q[DATA_W-1:0];

endmodule

// ===== tb/spidp_props.sv
// Wire checker for the host to device serial link
`timescale 1ns/100ps
module spidp_props
    import spidp_pkg::*;
(
    // System
    input wire logic CLK_SYS,
    input wire logic RST,
    // Link
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic chip_select_low_n
);
    logic       sck_q, sck_d;
    logic [7:0] ph_q, ph_d;
    logic [6:0] rise_q, rise_d;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // Phase length and rises per frame
    always_comb begin
        sck_d = sck;
        ph_d = (sck != sck_q) ? 8'h01 : ph_q + {7'h00, ph_q != 8'hff};
        rise_d = chip_select_low_n ? 7'h00 : rise_q + {6'h00, sck && !sck_q};
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sck_q <= 1'b1;
            ph_q <= 8'h00;
            rise_q <= 7'h00;
        end else begin
            sck_q <= sck_d;
            ph_q <= ph_d;
            rise_q <= rise_d;
        end
    end

    property p_idle_high;
        chip_select_low_n |-> sck;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("clock not high while deselected");
    property p_select_edge;
        $changed(chip_select_low_n) |-> sck ##1 sck;
    endproperty
    a_select_edge: assert property (p_select_edge)
        else $error("clock low around select change");
    property p_count40;
        $rose(chip_select_low_n) |-> rise_q == 7'h28;
    endproperty
    a_count40: assert property (p_count40)
        else $error("frame without forty clock rises");
    property p_phase;
        (sck != sck_q) |-> ph_q >= 8'h07;
    endproperty
    a_phase: assert property (p_phase)
        else $error("clock phase too short");
    property p_gap;
        $rose(chip_select_low_n) |-> chip_select_low_n [*5];
    endproperty
    a_gap: assert property (p_gap)
        else $error("deselect gap too short");
    property p_sdo_fall;
        $changed(sdo) |-> ($past(sck, 4) && !$past(sck, 3)) ||
            ($past(chip_select_low_n, 4) && !$past(chip_select_low_n, 3));
    endproperty
    a_sdo_fall: assert property (p_sdo_fall)
        else $error("data out moved off its falling clock slot");
    property p_stat7;
        $fell(chip_select_low_n) |-> ##3 !sdo;
    endproperty
    a_stat7: assert property (p_stat7)
        else $error("reserved status bit not zero");
    property p_sdi_move;
        $changed(sdi) && !chip_select_low_n |-> $fell(sck);
    endproperty
    a_sdi_move: assert property (p_sdi_move)
        else $error("data in moved outside falling clock");

    c_frame: cover property ($rose(chip_select_low_n));
    c_full: cover property (rise_q == 7'h28);
    c_sdo: cover property ($changed(sdo));
endmodule

// ===== tb/test_spi_slave_datagram_port.sv
// Bench: host and device back to back, plus a bench-driven second device
`timescale 1ns/100ps
module test_spi_slave_datagram_port import spidp_pkg::*;;
    logic        clk_sys, rst, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic        reg_wr, reg_rd, wr2, rd2, short1, short2;
    logic        busy1, busy2;
    logic [6:0]  cmd_addr, reg_addr, addr2;
    logic [7:0]  status, rsp_status, prev_stat;
    logic [31:0] cmd_data, rsp_data, reg_wdata, wdata2, reg_rdata, prev_data;
    logic [39:0] q_rsp[$];
    logic [40:0] q_cmd[$], q_cmd2[$];
    int          n_mismatch = 0, num_checks = 0, cycles = 0, n_s1 = 0;
    int          n_s2 = 0;
    integer      seed = 32'h3238c8ed;
    logic [7:0]  wpat = 8'he4;
    logic [39:0] exp2 = 40'h0;

    spidp_if link();
    spidp_if link2();
    spidp_host i_spidp_host (.CLK_SYS(clk_sys), .RST(rst), .LINK(link.host),
        .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
        .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
        .RSP_STATUS(rsp_status), .RSP_DATA(rsp_data));
    spidp_dev i_spidp_dev (.CLK_SYS(clk_sys), .RST(rst), .LINK(link.dev),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .STATUS(status),
        .BUSY(busy1), .SHORT_FRAME(short1));
    spidp_dev i_spidp_dev2 (.CLK_SYS(clk_sys), .RST(rst), .LINK(link2.dev),
        .REG_WR(wr2), .REG_RD(rd2), .REG_ADDR(addr2), .REG_WDATA(wdata2),
        .REG_RDATA(reg_rdata), .STATUS(status), .BUSY(busy2),
        .SHORT_FRAME(short2));
    spidp_props i_spidp_props (.CLK_SYS(clk_sys), .RST(rst), .sck(link.sck),
        .sdi(link.sdi), .sdo(link.sdo),
        .chip_select_low_n(link.chip_select_low_n));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp_rsp(input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED response exp %h got %h", e, g);
        end
    endtask

    task automatic cmp_cmd(string nm, input logic [40:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic cmp_wire(string nm, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    // One host command, with the reply and register command it implies
    task automatic issue(input logic w, input logic [6:0] a,
                         input logic [31:0] d);
        int k;
        k = 0;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 2000)
            n_mismatch++;
        q_rsp.push_back({prev_stat & 8'h7f, prev_data});
        q_cmd.push_back({w, !w, a, w ? d : 32'h0});
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_data = d;
        status = 8'($random(seed));
        reg_rdata = $random(seed);
        prev_stat = status;
        prev_data = w ? d : reg_rdata;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask

    // Bench-driven frame of n bits on the second link, 80 ns clock
    task automatic frame2(input int n, input logic [47:0] d);
        logic e;
        if (n >= 40)
            q_cmd2.push_back({d[39], !d[39], d[38:32], d[39] ? d[31:0] : 32'h0});
        link2.chip_select_low_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            link2.sck = 1'b0;
            link2.sdi = d[n-1-i];
            #40;
            e = i < 40 ? exp2[39-i] : d[n+39-i];
            cmp_wire("sdo2", {7'h0, e}, {7'h0, link2.sdo});
            cmp_wire("busy2", 8'h01, {7'h0, busy2});
            link2.sck = 1'b1;
            #40;
        end
        link2.sdi = ~link2.sdi;
        link2.chip_select_low_n = 1'b1;
        // Reply of the next frame: captured status and echo or read data
        if (n >= 40)
            exp2 = {status & 8'h7f, d[39] ? d[31:0] : reg_rdata};
        #400;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            n_mismatch++;
            print_verdict;
        end
    end

    // Result watchers
    always @(negedge clk_sys) begin
        if (rsp_valid === 1'b1)
            cmp_rsp(q_rsp.size() > 0 ? q_rsp.pop_front() : 'x, {rsp_status, rsp_data});
        if ((reg_wr | reg_rd) === 1'b1) begin
            cmp_cmd("cmd", q_cmd.size() > 0 ? q_cmd.pop_front() : 'x, {reg_wr, reg_rd, reg_addr, reg_wr ? reg_wdata : 32'h0});
            cmp_wire("busy1", 8'h00, {7'h0, busy1});
        end
        if ((wr2 | rd2) === 1'b1)
            cmp_cmd("cmd2", q_cmd2.size() > 0 ? q_cmd2.pop_front() : 'x, {wr2, rd2, addr2, wr2 ? wdata2 : 32'h0});
        n_s1 += int'(short1 === 1'b1);
        n_s2 += int'(short2 === 1'b1);
    end

    initial begin
        int k;
        logic [47:0] d;
        rst = 1'b1;
        {cmd_valid, cmd_write, cmd_addr, cmd_data} = '0;
        {status, reg_rdata, prev_stat, prev_data} = '0;
        link2.sck = 1'b1;
        link2.sdi = 1'b0;
        link2.chip_select_low_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 8; i++)
            issue(wpat[i], i == 0 ? 7'h7f : 7'($random(seed)), $random(seed));
        k = 0;
        while (q_rsp.size() > 0 && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 2000)
            n_mismatch++;
        frame2(20, 48'($random(seed)));
        d = {16'($random(seed)), 32'($random(seed))};
        d[39] = 1'b1;
        frame2(48, d);
        d = 48'($random(seed));
        d[39] = 1'b0;
        frame2(40, d);
        k = q_rsp.size() + q_cmd.size() + q_cmd2.size();
        cmp_wire("pending", 8'h00, 8'(k));
        cmp_wire("short2", 8'h01, 8'(n_s2));
        cmp_wire("short1", 8'h00, 8'(n_s1));
        print_verdict;
    end
endmodule
